// [rtl/dir_pkg.sv]
package dir_pkg;
  // ************************************************************
  // register offsets and layouts
  // ************************************************************
  localparam logic [7:0] OFS_BUS_ADDRESS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_RESET_CONTROL = 8'h01;
  localparam logic [6:0] RST_DEVICE_ADDRESS = 7'h60;
  localparam logic RST_ADDRESS_SOURCE_SELECT = 1'h0;
  localparam logic RST_ANALOG_POWER_DOWN = 1'h0;
  localparam int POS_ADDRESS_SOURCE_SELECT = 0;
  localparam int POS_DIGITAL_RESET_KEEP = 1;
  localparam int POS_DIGITAL_RESET_ALL = 0;
  localparam int POS_ANALOG_POWER_DOWN = 5;
  // cycles a digital reset pulse is held on the core
  localparam logic [1:0] DIGITAL_RESET_CYCLES = 2'h1;

  typedef struct packed {
    logic we;
    logic re;
    logic local_access;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dir_req_t;

  typedef struct packed {
    logic [6:0] device_address;
    logic address_source_select;
    logic analog_power_down;
    logic digital_reset_keep;
    logic digital_reset_all;
    logic [7:0] rdata;
  } dir_state_t;
endpackage

// [rtl/dir_regs.sv]
`timescale 1ns/10ps
// Function
// - writable 7-bit bus address, default 0x60
// - bit0 selects strap or register address
// - power-down set only by local access
// - power-down bit drives analog block off
// - bit1 resets logic, keeps registers, self-clears
// - bit0 resets logic and registers, self-clears
module dir_regs (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_WE,
  input wire logic I_RE,
  input wire logic I_LOCAL_ACCESS,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic [6:0] I_STRAP_ADDRESS_VALUE,
  output logic [7:0] O_RDATA,
  output logic [6:0] O_ACTIVE_ADDRESS,
  output logic [6:0] O_DEVICE_ADDRESS,
  output logic O_ADDRESS_SOURCE_SELECT,
  output logic O_ANALOG_POWER_DOWN,
  output logic O_DIGITAL_RESET
);
  dir_pkg::dir_req_t req;
  dir_pkg::dir_state_t state_reg;
  dir_pkg::dir_state_t state_next;
  logic [6:0] strap_meta_reg;
  logic [6:0] strap_sync_reg;
  logic wr_addr;
  logic wr_rst;

  // every check samples on the core clock and rests while reset is held
  default clocking dir_cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign req.we = I_WE;
  assign req.re = I_RE;
  assign req.local_access = I_LOCAL_ACCESS;
  assign req.addr = I_ADDR;
  assign req.wdata = I_WDATA;
  assign wr_addr = req.we && hit(req.addr, dir_pkg::OFS_BUS_ADDRESS_CONFIG);
  assign wr_rst = req.we && hit(req.addr, dir_pkg::OFS_RESET_CONTROL);

  // ************************************************************
  // strap pin synchroniser
  // ************************************************************
  always_ff @(posedge I_CORE_CLK)
  begin
    strap_meta_reg <= I_STRAP_ADDRESS_VALUE;
    strap_sync_reg <= strap_meta_reg;
  end

  // ************************************************************
  // register update
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    // reset pulses last one cycle, then clear themselves
    state_next.digital_reset_keep = 1'b0;
    state_next.digital_reset_all = 1'b0;
    state_next.rdata = 8'h00;
    if (state_reg.digital_reset_all)
    begin
      // full digital reset returns every register to default
      state_next.device_address = dir_pkg::RST_DEVICE_ADDRESS;
      state_next.address_source_select =
        dir_pkg::RST_ADDRESS_SOURCE_SELECT;
      state_next.analog_power_down = dir_pkg::RST_ANALOG_POWER_DOWN;
    end
    else
    begin
      if (wr_addr)
      begin
        state_next.device_address = req.wdata[7:1];
        state_next.address_source_select =
          req.wdata[dir_pkg::POS_ADDRESS_SOURCE_SELECT];
      end
      if (wr_rst)
      begin
        // remote writes cannot power down; writing 0 never clears it
        if (req.local_access && req.wdata[dir_pkg::POS_ANALOG_POWER_DOWN])
          state_next.analog_power_down = 1'b1;
        state_next.digital_reset_keep =
          req.wdata[dir_pkg::POS_DIGITAL_RESET_KEEP];
        state_next.digital_reset_all =
          req.wdata[dir_pkg::POS_DIGITAL_RESET_ALL];
      end
    end
    if (req.re && hit(req.addr, dir_pkg::OFS_BUS_ADDRESS_CONFIG))
      state_next.rdata = {state_reg.device_address,
                          state_reg.address_source_select};
    else if (req.re && hit(req.addr, dir_pkg::OFS_RESET_CONTROL))
      // reset bits are pulses and read back as zero
      state_next.rdata = {2'h0, state_reg.analog_power_down, 5'h00};
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      state_reg.device_address <= dir_pkg::RST_DEVICE_ADDRESS;
      state_reg.address_source_select <= dir_pkg::RST_ADDRESS_SOURCE_SELECT;
      state_reg.analog_power_down <= dir_pkg::RST_ANALOG_POWER_DOWN;
      state_reg.digital_reset_keep <= 1'b0;
      state_reg.digital_reset_all <= 1'b0;
      state_reg.rdata <= 8'h00;
    end
    else
      state_reg <= state_next;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign O_RDATA = state_reg.rdata;
  assign O_DEVICE_ADDRESS = state_reg.device_address;
  assign O_ADDRESS_SOURCE_SELECT = state_reg.address_source_select;
  assign O_ACTIVE_ADDRESS = state_reg.address_source_select ?
    state_reg.device_address : strap_sync_reg;
  assign O_ANALOG_POWER_DOWN = state_reg.analog_power_down;
  assign O_DIGITAL_RESET = state_reg.digital_reset_keep |
    state_reg.digital_reset_all;

  // ************************************************************
  // checks
  // ************************************************************
  // address field and select bit come from one write byte
  a_addr_write: assert property (
    wr_addr && !state_reg.digital_reset_all |=>
    O_DEVICE_ADDRESS == $past(I_WDATA[7:1]))
    else $error("address write not stored");

  a_addr_hold: assert property (
    !wr_addr && !state_reg.digital_reset_all |=>
    $stable(O_DEVICE_ADDRESS))
    else $error("address changed without a write");

  a_addr_read: assert property (
    I_RE && I_ADDR == dir_pkg::OFS_BUS_ADDRESS_CONFIG |=>
    O_RDATA == {$past(O_DEVICE_ADDRESS), $past(O_ADDRESS_SOURCE_SELECT)})
    else $error("address readback wrong");

  a_select_write: assert property (
    wr_addr && !state_reg.digital_reset_all |=>
    O_ADDRESS_SOURCE_SELECT == $past(I_WDATA[0]))
    else $error("select bit write not stored");

  a_select_hold: assert property (
    !wr_addr && !state_reg.digital_reset_all |=>
    $stable(O_ADDRESS_SOURCE_SELECT))
    else $error("select bit changed without a write");

  a_addr_select: assert property (
    O_ACTIVE_ADDRESS == (O_ADDRESS_SOURCE_SELECT ?
      O_DEVICE_ADDRESS : strap_sync_reg))
    else $error("active address source wrong");

  // a remote write must never be the cause of an analog shutdown
  a_remote_pwdn: assert property (
    !O_ANALOG_POWER_DOWN && !(wr_rst && I_LOCAL_ACCESS) |=>
    !O_ANALOG_POWER_DOWN)
    else $error("power-down set without local access");

  a_local_pwdn: assert property (
    wr_rst && I_LOCAL_ACCESS && I_WDATA[5] &&
    !state_reg.digital_reset_all |=> O_ANALOG_POWER_DOWN)
    else $error("local power-down write ignored");

  a_pwdn_sticky: assert property (
    O_ANALOG_POWER_DOWN && !state_reg.digital_reset_all |=>
    O_ANALOG_POWER_DOWN)
    else $error("power-down cleared by write");

  a_pwdn_read: assert property (
    I_RE && I_ADDR == dir_pkg::OFS_RESET_CONTROL |=>
    O_RDATA[5] == $past(O_ANALOG_POWER_DOWN))
    else $error("power-down readback wrong");

  a_keep_pulse: assert property (
    wr_rst && I_WDATA[1] && !state_reg.digital_reset_all |=>
    O_DIGITAL_RESET ##1 (!state_reg.digital_reset_keep))
    else $error("keep reset pulse wrong");

  a_keep_regs: assert property (
    state_reg.digital_reset_keep && !state_reg.digital_reset_all && !wr_addr
    |=> $stable(O_DEVICE_ADDRESS))
    else $error("keep reset altered registers");

  // a pulse that is not renewed by a write must drop after one cycle
  a_reset_clears: assert property (
    O_DIGITAL_RESET && !wr_rst |=>
    !O_DIGITAL_RESET)
    else $error("reset pulse did not clear");

  a_all_pulse: assert property (
    wr_rst && I_WDATA[0] && !state_reg.digital_reset_all |=>
    O_DIGITAL_RESET ##1 !O_DIGITAL_RESET)
    else $error("full reset pulse wrong");

  a_all_defaults: assert property (
    state_reg.digital_reset_all |=> O_DEVICE_ADDRESS == 7'h60 &&
    !O_ADDRESS_SOURCE_SELECT && !O_ANALOG_POWER_DOWN)
    else $error("full reset left registers set");

  a_rsvd_zero: assert property (
    I_RE && I_ADDR == 8'h01 |=>
    (O_RDATA & 8'hDF) == 8'h00)
    else $error("reserved reset bits read nonzero");

  // read data stands one cycle only, so a stale value cannot be taken twice
  a_rdata_idle: assert property (
    !I_RE |=>
    O_RDATA == 8'h00)
    else $error("read data without a read");

  a_unmapped_read: assert property (
    I_RE && I_ADDR > dir_pkg::OFS_RESET_CONTROL |=>
    O_RDATA == 8'h00)
    else $error("unmapped offset read nonzero");
endmodule

// [tb/dir_host.sv]
`timescale 1ns/10ps
module dir_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output dir_pkg::dir_req_t o_req
);
  // ******************************
  // local bus host
  // ******************************
  initial o_req = '0;
  // released address and data show the inverse, never the last value
  task automatic wr(input logic l, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_req = {1'b1, 1'b0, l, a, d};
    @(negedge i_clk);
    o_req = {3'b000, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_req = {3'b011, a, 8'h00};
    @(negedge i_clk);
    o_req = {3'b000, ~a, 8'hFF};
    d = i_rdata;
  endtask
endmodule

// [tb/tb_deser_id_and_reset_regs.sv]
`timescale 1ns/10ps
module tb_deser_id_and_reset_regs;
  logic clk, rst, pwdn, drst, sel;
  logic [7:0] rdata, rv;
  logic [6:0] strap, act, dev;
  int bad_count, n_compared;
  dir_pkg::dir_req_t req;
  dir_regs dut (.I_CORE_CLK(clk), .I_RST(rst), .I_WE(req.we),
    .I_RE(req.re), .I_LOCAL_ACCESS(req.local_access), .I_ADDR(req.addr),
    .I_WDATA(req.wdata), .I_STRAP_ADDRESS_VALUE(strap), .O_RDATA(rdata),
    .O_ACTIVE_ADDRESS(act), .O_DEVICE_ADDRESS(dev),
    .O_ADDRESS_SOURCE_SELECT(sel), .O_ANALOG_POWER_DOWN(pwdn),
    .O_DIGITAL_RESET(drst));
  dir_host host (.i_clk(clk), .i_rdata(rdata), .o_req(req));
  // ******************************
  // checks and scenarios
  // ******************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic t_defaults;
    rchk(8'h00, 8'hC0);
    rchk(8'h01, 8'h00);
    chk({1'b0, act}, 8'h33);
    chk({7'h00, sel}, 8'h00);
    $display("defaults done");
  endtask
  task automatic t_address;
    host.wr(1'b1, 8'h00, 8'h55);
    rchk(8'h00, 8'h55);
    chk({1'b0, act}, 8'h2A);
    chk({7'h00, sel}, 8'h01);
    host.wr(1'b1, 8'h00, 8'hA4);
    chk({act, 1'b0}, 8'h66);
    chk({dev, 1'b0}, 8'hA4);
    chk({7'h00, sel}, 8'h00);
    host.wr(1'b1, 8'h02, 8'hFF);
    rchk(8'h02, 8'h00);
    rchk(8'h00, 8'hA4);
    $display("address done");
  endtask
  task automatic t_power;
    host.wr(1'b0, 8'h01, 8'h20);
    chk({7'h00, pwdn}, 8'h00);
    host.wr(1'b1, 8'h01, 8'hFC);
    chk({7'h00, pwdn}, 8'h01);
    host.wr(1'b1, 8'h01, 8'h00);
    rchk(8'h01, 8'h20);
    $display("power done");
  endtask
  task automatic t_resets;
    host.wr(1'b1, 8'h01, 8'h22);
    chk({7'h00, drst}, 8'h01);
    @(negedge clk);
    chk({7'h00, drst}, 8'h00);
    rchk(8'h01, 8'h20);
    rchk(8'h00, 8'hA4);
    host.wr(1'b1, 8'h01, 8'h01);
    chk({7'h00, drst}, 8'h01);
    @(negedge clk);
    rchk(8'h00, 8'hC0);
    rchk(8'h01, 8'h00);
    $display("resets done");
  endtask
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // strap held steady so its two-flop sync settles during reset
  initial
  begin
    rst = 1'b1;
    strap = 7'h33;
    bad_count = 0;
    n_compared = 0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_defaults();
    t_address();
    t_power();
    t_resets();
    complete_run();
  end
  initial
  begin
    #50000;
    bad_count++;
    complete_run();
  end
endmodule
